/* File: pwr_pkg.sv */
// Constants, register layout and sense carrier for the dual-slot power and fault control.
// Assumes a 40 MHz clock and an analog front end that delivers clean, synchronous flags.
package pwr_pkg;
   localparam int unsigned CLK_MHZ     = 40;
   localparam int unsigned POR_TIME_US = 500;
   localparam int unsigned POR_CYCLES  = POR_TIME_US * CLK_MHZ;
   localparam logic [15:0] FAULT_DELAY_CYCLES = 16'h0190;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL_A = 6'h02;
   localparam logic [5:0] IDX_CTRL_B = 6'h03;
   localparam logic [5:0] IDX_STAT_A = 6'h04;
   localparam logic [5:0] IDX_STAT_B = 6'h05;
   localparam logic [5:0] IDX_COMMON = 6'h06;

   // Slot control register fields
   localparam int CTRL_AUX_EN  = 0;
   localparam int CTRL_MAIN_EN = 1;
   localparam int CTRL_MAIN_PG = 6;
   localparam int CTRL_AUX_PG  = 7;

   // Slot status register fields, write one to clear
   localparam int STAT_MAIN_FLT = 0;
   localparam int STAT_AUX_FLT  = 1;
   localparam int STAT_OT_FLT   = 2;
   localparam int STAT_UV_FLT   = 3;
   localparam int STAT_W        = 4;

   // Common status register fields
   localparam int COM_FLT_A    = 0;
   localparam int COM_FLT_B    = 1;
   localparam int COM_DIE_OT   = 2;
   localparam int COM_INT_MASK = 7;

   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Per-slot flags from the analog front end
   typedef struct packed {
      logic [3:0] over_limit;
      logic [3:0] fast_trip;
      logic       aux_over_limit;
      logic       overtemp;
   } slot_sense_s;
endpackage

/* File: dual_slot_power_fault_control.sv */
// Turn-on, turn-off, breaker and fault reporting for two hot-plug slots, with AXI4-Lite registers.
// Assumes all inputs synchronous to clk; main_uv bit set means that input is below lockout.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module dual_slot_power_fault_control #(
   parameter int unsigned POR_CYCLES         = pwr_pkg::POR_CYCLES,
   parameter logic [15:0] FAULT_DELAY_CYCLES = pwr_pkg::FAULT_DELAY_CYCLES
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // Supplies
   input  wire logic                      standby_supply,
   input  wire logic [3:0]                main_uv,
   // Hot-plug pins
   input  wire logic [1:0]                main_enable_pin,
   input  wire logic [1:0]                aux_enable_pin,
   // Analog flags
   input  wire pwr_pkg::slot_sense_s [1:0] slot_sense,
   input  wire logic                      die_overtemp_flag,
   // AXI4-Lite write
   input  wire logic [7:0]                awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   // AXI4-Lite read
   input  wire logic [7:0]                araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   // Slot drive
   output logic [1:0]                     main_gate_ff,
   output logic [1:0]                     main_discharge_ff,
   output logic [1:0]                     aux_output_ff,
   output logic [1:0]                     aux_discharge_ff,
   output logic [1:0]                     fault_n_ff,
   output logic                           int_n_ff,
   output logic                           standby_mode_ff
);

   function automatic logic reg_mapped(input logic [7:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      reg_mapped = (addr[1:0] == 2'h0) && (idx >= pwr_pkg::IDX_CTRL_A)
                   && (idx <= pwr_pkg::IDX_COMMON);
   endfunction

   logic [14:0] por_cnt_ff;
   logic        por_done_ff;
   logic [1:0]  main_bit_ff;
   logic [1:0]  aux_bit_ff;
   logic [1:0]  main_trip_ff;
   logic [1:0]  aux_trip_ff;
   logic [1:0]  ot_trip_ff;
   logic        die_trip_ff;
   logic [15:0] main_cnt_ff [2];
   logic [15:0] aux_cnt_ff [2];
   logic [pwr_pkg::STAT_W-1:0] stat_ff [2];
   logic        die_stat_ff;
   logic        mask_ff;

   logic [1:0]  main_req;
   logic [1:0]  aux_req;
   logic [1:0]  pin_mode;
   logic [1:0]  main_oc_expired;
   logic [1:0]  main_fast;
   logic [1:0]  uv_trip;
   logic [1:0]  main_trip_set;
   logic [1:0]  aux_trip_set;
   logic [1:0]  nxt_main_gate;
   logic [1:0]  nxt_aux_output;
   logic [1:0]  nxt_fault_n;
   logic [pwr_pkg::STAT_W-1:0] nxt_stat [2];
   logic [pwr_pkg::STAT_W-1:0] stat_clr [2];
   logic        nxt_die_stat;
   logic        nxt_mask;
   logic        uv_any;
   logic        wr_en;
   logic [5:0]  wr_idx;
   logic        wr_low;
   logic        rd_en;
   logic [5:0]  rd_idx;
   logic [7:0]  rd_byte;

   assign uv_any = |main_uv;
   assign wr_en  = awready && awvalid && wvalid;
   assign wr_idx = awaddr[7:2];
   assign wr_low = wstrb[0] && reg_mapped(awaddr);
   assign rd_en  = arready && arvalid;
   assign rd_idx = araddr[7:2];

   // Power-on reset interval after standby supply becomes valid
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         por_cnt_ff  <= 15'h0000;
         por_done_ff <= 1'b0;
      end else if (!standby_supply) begin
         por_cnt_ff  <= 15'h0000;
         por_done_ff <= 1'b0;
      end else if (!por_done_ff) begin
         if (por_cnt_ff == 15'(POR_CYCLES - 1)) begin
            por_done_ff <= 1'b1;
         end
         por_cnt_ff <= por_cnt_ff + 15'h0001;
      end
   end

   // Trip conditions per slot
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         main_req[s] = main_enable_pin[s] | main_bit_ff[s];
         aux_req[s]  = aux_enable_pin[s] | aux_bit_ff[s];
         pin_mode[s] = main_enable_pin[s] | aux_enable_pin[s];
         main_oc_expired[s] = main_gate_ff[s] && (|slot_sense[s].over_limit)
                              && (main_cnt_ff[s] == FAULT_DELAY_CYCLES - 16'h0001);
         main_fast[s] = main_gate_ff[s] && (|slot_sense[s].fast_trip);
         uv_trip[s]   = main_req[s] && uv_any;
         main_trip_set[s] = main_oc_expired[s] || main_fast[s] || uv_trip[s];
         aux_trip_set[s]  = aux_output_ff[s] && slot_sense[s].aux_over_limit
                            && (aux_cnt_ff[s] == FAULT_DELAY_CYCLES - 16'h0001);
         nxt_main_gate[s] = main_req[s] && !uv_any && !main_trip_ff[s] && !main_trip_set[s]
                            && !ot_trip_ff[s] && !slot_sense[s].overtemp
                            && !die_trip_ff && !die_overtemp_flag;
         nxt_aux_output[s] = aux_req[s] && !aux_trip_ff[s] && !aux_trip_set[s]
                             && !ot_trip_ff[s] && !slot_sense[s].overtemp
                             && !die_trip_ff && !die_overtemp_flag;
         nxt_fault_n[s] = !((pin_mode[s] && (main_trip_ff[s] || main_trip_set[s]
                             || aux_trip_ff[s] || aux_trip_set[s]))
                            || ot_trip_ff[s] || slot_sense[s].overtemp);
      end
   end

   // Fault delay counters restart when the overload goes away
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_cnt_ff <= '{default: 16'h0000};
         aux_cnt_ff  <= '{default: 16'h0000};
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (main_gate_ff[s] && (|slot_sense[s].over_limit) && !main_oc_expired[s]) begin
               main_cnt_ff[s] <= main_cnt_ff[s] + 16'h0001;
            end else begin
               main_cnt_ff[s] <= 16'h0000;
            end
            if (aux_output_ff[s] && slot_sense[s].aux_over_limit && !aux_trip_set[s]) begin
               aux_cnt_ff[s] <= aux_cnt_ff[s] + 16'h0001;
            end else begin
               aux_cnt_ff[s] <= 16'h0000;
            end
         end
      end
   end

   // Breaker latches; a new trip wins over the release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_trip_ff <= 2'h0;
         aux_trip_ff  <= 2'h0;
         ot_trip_ff   <= 2'h0;
         die_trip_ff  <= 1'b0;
      end else if (!por_done_ff) begin
         main_trip_ff <= 2'h0;
         aux_trip_ff  <= 2'h0;
         ot_trip_ff   <= 2'h0;
         die_trip_ff  <= 1'b0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (main_trip_set[s]) begin
               main_trip_ff[s] <= 1'b1;
            end else if (!main_req[s]) begin
               main_trip_ff[s] <= 1'b0;
            end
            if (aux_trip_set[s]) begin
               aux_trip_ff[s] <= 1'b1;
            end else if (!aux_req[s]) begin
               aux_trip_ff[s] <= 1'b0;
            end
            if (slot_sense[s].overtemp) begin
               ot_trip_ff[s] <= 1'b1;
            end else if (!main_req[s] && !aux_req[s]) begin
               ot_trip_ff[s] <= 1'b0;
            end
         end
         if (die_overtemp_flag) begin
            die_trip_ff <= 1'b1;
         end else if (main_req == 2'h0 && aux_req == 2'h0) begin
            die_trip_ff <= 1'b0;
         end
      end
   end

   // Output drive
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_gate_ff      <= 2'h0;
         main_discharge_ff <= 2'h3;
         aux_output_ff     <= 2'h0;
         aux_discharge_ff  <= 2'h3;
         fault_n_ff        <= 2'h3;
         standby_mode_ff   <= 1'b0;
      end else if (!por_done_ff) begin
         main_gate_ff      <= 2'h0;
         main_discharge_ff <= 2'h3;
         aux_output_ff     <= 2'h0;
         aux_discharge_ff  <= 2'h3;
         fault_n_ff        <= 2'h3;
         standby_mode_ff   <= 1'b0;
      end else begin
         main_gate_ff      <= nxt_main_gate;
         main_discharge_ff <= ~nxt_main_gate;
         aux_output_ff     <= nxt_aux_output;
         aux_discharge_ff  <= ~nxt_aux_output;
         fault_n_ff        <= nxt_fault_n;
         standby_mode_ff   <= uv_any;
      end
   end

   // Status next state; set wins over write-one-to-clear
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         stat_clr[s] = '0;
         if (wr_en && wr_low && wr_idx == (s == 0 ? pwr_pkg::IDX_STAT_A : pwr_pkg::IDX_STAT_B)) begin
            stat_clr[s] = wdata[pwr_pkg::STAT_W-1:0];
         end
         if (wr_en && wr_low && wr_idx == pwr_pkg::IDX_COMMON
             && wdata[s == 0 ? pwr_pkg::COM_FLT_A : pwr_pkg::COM_FLT_B]) begin
            stat_clr[s] = '1;
         end
         nxt_stat[s] = stat_ff[s] & ~stat_clr[s];
         if ((main_oc_expired[s] || main_fast[s]) && !main_trip_ff[s]) begin
            nxt_stat[s][pwr_pkg::STAT_MAIN_FLT] = 1'b1;
         end
         if (uv_trip[s] && !main_trip_ff[s]) begin
            nxt_stat[s][pwr_pkg::STAT_UV_FLT] = 1'b1;
         end
         if (aux_trip_set[s] && !aux_trip_ff[s]) begin
            nxt_stat[s][pwr_pkg::STAT_AUX_FLT] = 1'b1;
         end
         if (slot_sense[s].overtemp && !ot_trip_ff[s]) begin
            nxt_stat[s][pwr_pkg::STAT_OT_FLT] = 1'b1;
         end
      end
      nxt_die_stat = die_stat_ff;
      nxt_mask     = mask_ff;
      if (wr_en && wr_low && wr_idx == pwr_pkg::IDX_COMMON) begin
         nxt_mask = wdata[pwr_pkg::COM_INT_MASK];
         if (wdata[pwr_pkg::COM_DIE_OT]) begin
            nxt_die_stat = 1'b0;
         end
      end
      if (die_overtemp_flag && !die_trip_ff) begin
         nxt_die_stat = 1'b1;
      end
   end

   // Status, mask and interrupt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat_ff     <= '{default: '0};
         die_stat_ff <= 1'b0;
         mask_ff     <= 1'b0;
         int_n_ff    <= 1'b1;
      end else if (!por_done_ff) begin
         stat_ff     <= '{default: '0};
         die_stat_ff <= 1'b0;
         mask_ff     <= 1'b0;
         int_n_ff    <= 1'b1;
      end else begin
         stat_ff     <= nxt_stat;
         die_stat_ff <= nxt_die_stat;
         mask_ff     <= nxt_mask;
         int_n_ff    <= !((|nxt_stat[0] || |nxt_stat[1] || nxt_die_stat) && !nxt_mask);
      end
   end

   // Control register enable bits
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_bit_ff <= 2'h0;
         aux_bit_ff  <= 2'h0;
      end else if (!por_done_ff) begin
         main_bit_ff <= 2'h0;
         aux_bit_ff  <= 2'h0;
      end else if (wr_en && wr_low) begin
         if (wr_idx == pwr_pkg::IDX_CTRL_A) begin
            main_bit_ff[0] <= wdata[pwr_pkg::CTRL_MAIN_EN];
            aux_bit_ff[0]  <= wdata[pwr_pkg::CTRL_AUX_EN];
         end
         if (wr_idx == pwr_pkg::IDX_CTRL_B) begin
            main_bit_ff[1] <= wdata[pwr_pkg::CTRL_MAIN_EN];
            aux_bit_ff[1]  <= wdata[pwr_pkg::CTRL_AUX_EN];
         end
      end
   end

   // Read data selection
   always_comb begin
      rd_byte = pwr_pkg::RESET_BYTE;
      case (rd_idx)
         pwr_pkg::IDX_CTRL_A, pwr_pkg::IDX_CTRL_B: begin
            // Odd index is slot B
            rd_byte[pwr_pkg::CTRL_MAIN_EN] = main_bit_ff[rd_idx[0]];
            rd_byte[pwr_pkg::CTRL_AUX_EN]  = aux_bit_ff[rd_idx[0]];
            rd_byte[pwr_pkg::CTRL_MAIN_PG] = main_gate_ff[rd_idx[0]];
            rd_byte[pwr_pkg::CTRL_AUX_PG]  = aux_output_ff[rd_idx[0]];
         end
         pwr_pkg::IDX_STAT_A: rd_byte[pwr_pkg::STAT_W-1:0] = stat_ff[0];
         pwr_pkg::IDX_STAT_B: rd_byte[pwr_pkg::STAT_W-1:0] = stat_ff[1];
         pwr_pkg::IDX_COMMON: begin
            rd_byte[pwr_pkg::COM_FLT_A]    = |stat_ff[0];
            rd_byte[pwr_pkg::COM_FLT_B]    = |stat_ff[1];
            rd_byte[pwr_pkg::COM_DIE_OT]   = die_stat_ff;
            rd_byte[pwr_pkg::COM_INT_MASK] = mask_ff;
         end
         default: rd_byte = pwr_pkg::RESET_BYTE;
      endcase
   end

   // AXI4-Lite write channel: address and data taken together
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= pwr_pkg::RESP_OKAY;
      end else begin
         awready <= awvalid && wvalid && !awready && !bvalid;
         wready  <= awvalid && wvalid && !awready && !bvalid;
         if (wr_en) begin
            bvalid <= 1'b1;
            bresp  <= reg_mapped(awaddr) ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= pwr_pkg::RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (rd_en) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, reg_mapped(araddr) ? rd_byte : pwr_pkg::RESET_BYTE};
            rresp  <= reg_mapped(araddr) ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !por_done_ff);

   sequence oc_held_s;
      main_gate_ff[0] && (|slot_sense[0].over_limit)
         && main_cnt_ff[0] == FAULT_DELAY_CYCLES - 16'h0001;
   endsequence

   sequence mains_dark_s;
      !main_gate_ff[0] && !main_gate_ff[1];
   endsequence

   gate_off_a: assert property (!main_req[0] |=> !main_gate_ff[0] && main_discharge_ff[0])
      else $error("gate on while slot off");
   turn_on_a: assert property (main_req[0] && !uv_any && !main_trip_ff[0] && !ot_trip_ff[0]
      && !die_trip_ff && !die_overtemp_flag && !slot_sense[0].overtemp
      && !main_trip_set[0] |=> main_gate_ff[0])
      else $error("mains did not turn on");
   discharge_a: assert property ($fell(main_gate_ff[1]) |-> main_discharge_ff[1])
      else $error("no discharge after turn off");
   standby_a: assert property (uv_any |=> standby_mode_ff and mains_dark_s)
      else $error("undervoltage did not enter standby");
   aux_survives_a: assert property (aux_req[0] && uv_any && !aux_trip_ff[0] && !ot_trip_ff[0]
      && !die_trip_ff && !die_overtemp_flag && !slot_sense[0].overtemp && !aux_trip_set[0]
      |=> aux_output_ff[0])
      else $error("aux dropped on undervoltage");
   uv_fault_a: assert property (main_enable_pin[0] && uv_any |=> !fault_n_ff[0])
      else $error("no fault on undervoltage");
   delay_trip_a: assert property (oc_held_s |=> !main_gate_ff[0] ##1 main_trip_ff[0]
      || !main_req[0])
      else $error("delayed trip missed");
   fast_trip_a: assert property (main_gate_ff[1] && |slot_sense[1].fast_trip
      |=> !main_gate_ff[1] && stat_ff[1][pwr_pkg::STAT_MAIN_FLT])
      else $error("fast trip missed");
   reg_fault_pin_a: assert property (!pin_mode[0] && !ot_trip_ff[0] && !slot_sense[0].overtemp
      |=> fault_n_ff[0])
      else $error("fault pin in register mode");
   int_raise_a: assert property ($rose(stat_ff[0][pwr_pkg::STAT_MAIN_FLT]) && !mask_ff
      |-> !int_n_ff)
      else $error("interrupt not raised with trip");
   mask_hold_a: assert property (mask_ff |-> int_n_ff)
      else $error("interrupt while masked");
   die_off_a: assert property (die_overtemp_flag |=> mains_dark_s
      and (aux_output_ff == 2'h0 && die_stat_ff))
      else $error("die overtemperature left outputs on");
   slot_ot_a: assert property (slot_sense[0].overtemp |=> !aux_output_ff[0]
      && !main_gate_ff[0] && !fault_n_ff[0])
      else $error("slot overtemperature not handled");
endmodule // dual_slot_power_fault_control

/* File: hotplug_host_model.sv */
// Hot-plug controller model that drives the slot enable pins.
// Assumes the bench sets the wanted levels; slot A pins follow one edge later, slot B pins stay low.
`timescale 1ns/1ps
module hotplug_host_model (
   // Clock, reset and wanted levels
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [1:0] main_req,
   input  wire logic [1:0] aux_req,
   // Enable pins
   output logic [1:0]      main_pin_ff,
   output logic [1:0]      aux_pin_ff
);
   // Slot A pins follow the wanted levels one edge later, mains and aux together; slot B is bus driven only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_pin_ff <= 2'h0;
         aux_pin_ff  <= 2'h0;
      end else begin
         main_pin_ff <= main_req & 2'h1;
         aux_pin_ff  <= aux_req & 2'h1;
      end
   end
endmodule // hotplug_host_model

/* File: dual_slot_power_fault_control_tb.sv */
// Self-checking bench for the dual-slot power and fault control.
// Assumes the design and the host model compiled before it.
`timescale 1ns/1ps
module dual_slot_power_fault_control_tb;
   localparam logic [7:0] A_CA = {pwr_pkg::IDX_CTRL_A, 2'h0};
   localparam logic [7:0] A_CB = {pwr_pkg::IDX_CTRL_B, 2'h0};
   localparam logic [7:0] A_SA = {pwr_pkg::IDX_STAT_A, 2'h0};
   localparam logic [7:0] A_CO = {pwr_pkg::IDX_COMMON, 2'h0};
   logic        clk, resetn, standby_supply, die_overtemp_flag;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [3:0]  main_uv, wstrb;
   logic [7:0]  awaddr, araddr, rd_b;
   logic [31:0] wdata, rdata;
   logic [1:0]  mreq, areq, rr, bresp, rresp, main_enable_pin, aux_enable_pin;
   logic [1:0]  main_gate_ff, main_discharge_ff, aux_output_ff, aux_discharge_ff, fault_n_ff;
   logic        awready, wready, bvalid, arready, rvalid, int_n_ff, standby_mode_ff;
   pwr_pkg::slot_sense_s [1:0] slot_sense;
   int          error_cnt = 0;
   int          compares = 0;

   dual_slot_power_fault_control #(.POR_CYCLES(32'h8), .FAULT_DELAY_CYCLES(16'h0004)) i_dut (
      .clk(clk), .resetn(resetn), .standby_supply(standby_supply), .main_uv(main_uv),
      .main_enable_pin(main_enable_pin), .aux_enable_pin(aux_enable_pin),
      .slot_sense(slot_sense), .die_overtemp_flag(die_overtemp_flag), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .main_gate_ff(main_gate_ff), .main_discharge_ff(main_discharge_ff),
      .aux_output_ff(aux_output_ff), .aux_discharge_ff(aux_discharge_ff),
      .fault_n_ff(fault_n_ff), .int_n_ff(int_n_ff), .standby_mode_ff(standby_mode_ff));
   hotplug_host_model i_host (.clk(clk), .resetn(resetn), .main_req(mreq), .aux_req(areq),
      .main_pin_ff(main_enable_pin), .aux_pin_ff(aux_enable_pin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge clk); while (bvalid !== 1'b1);
      rr = bresp;
      bready  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rd_b = rdata[7:0];
      rr   = rresp;
      rready <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(rd_b, e);
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Cuts a hang short
   initial begin
      tick(5000);
      error_cnt++;
      results();
   end

   initial begin
      {resetn, die_overtemp_flag, awvalid, wvalid, bready, arvalid, rready} = '0;
      {main_uv, wstrb, awaddr, araddr, wdata, mreq, areq, slot_sense} = '0;
      standby_supply = 1'b1;
      tick(20);
      resetn <= 1'b1;
      tick(12);
      chk(main_gate_ff, 2'h0);
      chk(main_discharge_ff, 2'h3);
      rdc(A_CA, 8'h00);
      rd(8'h1C);
      chk(rr, pwr_pkg::RESP_SLVERR);
      // Slot A by pins
      mreq <= 2'h1;
      areq <= 2'h1;
      tick(4);
      chk(main_gate_ff, 2'h1);
      chk(main_discharge_ff, 2'h2);
      chk(aux_output_ff, 2'h1);
      chk(aux_discharge_ff, 2'h2);
      slot_sense[0].fast_trip <= 4'h2;
      tick(2);
      chk(main_gate_ff, 2'h0);
      chk(aux_output_ff, 2'h1);
      chk(fault_n_ff, 2'h2);
      chk(int_n_ff, 1'b0);
      slot_sense[0].fast_trip <= 4'h0;
      rdc(A_SA, 8'h01);
      wr(A_SA, 8'h01);
      chk(rr, pwr_pkg::RESP_OKAY);
      tick(2);
      chk(int_n_ff, 1'b1);
      mreq <= 2'h0;
      tick(4);
      mreq <= 2'h1;
      tick(4);
      chk(main_gate_ff, 2'h1);
      // Overload that drops early restarts the delay
      slot_sense[0].over_limit <= 4'h8;
      tick(3);
      slot_sense[0].over_limit <= 4'h0;
      tick(1);
      slot_sense[0].over_limit <= 4'h8;
      tick(3);
      chk(main_gate_ff, 2'h1);
      tick(4);
      chk(main_gate_ff, 2'h0);
      slot_sense[0].over_limit <= 4'h0;
      slot_sense[0].aux_over_limit <= 1'b1;
      tick(2);
      chk(aux_output_ff, 2'h1);
      tick(5);
      chk(aux_output_ff, 2'h0);
      slot_sense[0].aux_over_limit <= 1'b0;
      wr(A_CO, 8'h01);
      tick(2);
      chk(int_n_ff, 1'b1);
      mreq <= 2'h0;
      areq <= 2'h0;
      tick(4);
      mreq <= 2'h1;
      areq <= 2'h1;
      tick(4);
      chk({main_gate_ff, aux_output_ff}, 4'h5);
      // Input undervoltage with and without main enabled
      main_uv <= 4'h4;
      tick(3);
      chk(standby_mode_ff, 1'b1);
      chk(main_gate_ff, 2'h0);
      chk({fault_n_ff, int_n_ff}, 3'h4);
      chk(aux_output_ff, 2'h1);
      mreq <= 2'h0;
      main_uv <= 4'h0;
      tick(4);
      wr(A_CO, 8'h01);
      main_uv <= 4'h4;
      tick(3);
      chk({fault_n_ff, int_n_ff}, 3'h7);
      main_uv <= 4'h0;
      mreq <= 2'h1;
      tick(4);
      // Slot B by registers, interrupts masked
      wr(A_CO, 8'h80);
      wr(A_CB, 8'h03);
      tick(3);
      rdc(A_CB, 8'hC3);
      slot_sense[1].fast_trip <= 4'h1;
      tick(2);
      chk(main_gate_ff, 2'h1);
      chk(fault_n_ff, 2'h3);
      chk(int_n_ff, 1'b1);
      slot_sense[1].fast_trip <= 4'h0;
      wr(A_CB, 8'h01);
      wr(A_CB, 8'h03);
      tick(3);
      chk(main_gate_ff, 2'h3);
      // Temperature shutdowns
      slot_sense[0].overtemp <= 1'b1;
      tick(2);
      chk({main_gate_ff, aux_output_ff}, 4'hA);
      chk(fault_n_ff, 2'h2);
      slot_sense[0].overtemp <= 1'b0;
      die_overtemp_flag <= 1'b1;
      tick(2);
      chk({main_gate_ff, aux_output_ff}, 4'h0);
      die_overtemp_flag <= 1'b0;
      rdc(A_CO, 8'h87);
      results();
   end
endmodule // dual_slot_power_fault_control_tb
